/* hdl/sgu_top.sv */
// Purpose: reset stretch and power-mode clock gating for the core complex
// Assumes: reset pin and detectors are asynchronous; wake and debug inputs are on clk_sys
// Notes:   releases go core first, then memory, then peripherals
`timescale 1ns/100ps
module sgu_top #(
	parameter logic [21:0] POR_HOLD = sgu_pkg::POR_CLKS
) (
	input  wire logic              clk_sys,
	input  wire logic              srst,
	input  wire logic              por_det,
	input  wire logic              rst_pin_n,
	input  wire logic              wdog_rst,
	input  wire logic              sw_rst,
	input  wire logic              flash_secure,
	input  wire logic              debug_mode,
	input  wire logic              wait_instr,
	input  wire logic              stop_instr,
	input  wire logic              can_activity,
	input  wire logic              ungated_irq,
	input  wire sgu_pkg::sgu_ctrl_s ctrl,
	input  wire logic [15:0]       pce,
	input  wire logic              omr_we,
	input  wire logic [15:0]       omr_wdata,
	input  wire logic              scr_we,
	input  wire logic [1:0]        scr_sel,
	input  wire logic [15:0]       scr_wdata,
	output logic                   core_rst,
	output logic                   mem_rst,
	output logic                   periph_rst,
	output logic                   core_clk_en,
	output logic                   mem_clk_en,
	output logic [15:0]            periph_clk_en,
	output logic                   wdog_clk_en,
	output logic                   can_clk_en,
	output logic                   pwm_force_off,
	output logic [1:0]             pmode,
	output logic [15:0]            omr_q,
	output logic [63:0]            scr_q
);
	// Two-flop synchronisers for async sources
	logic por_s1_r, por_s2_r, pin_s1_r, pin_s2_r;
	always_ff @(posedge clk_sys) begin
		por_s1_r <= por_det;
		por_s2_r <= por_s1_r;
		pin_s1_r <= ~rst_pin_n;
		pin_s2_r <= pin_s1_r;
	end

	sgu_pkg::sgu_rsrc_s src;
	// One driver for the whole struct, so no field has two writers
	assign src = '{
		por:  por_s2_r | srst,
		ext:  pin_s2_r,
		wdog: wdog_rst,
		sw:   sw_rst
	};
	wire any_src = src.por | src.ext | src.wdog | src.sw;
	wire hard_src = src.por | src.ext;

	logic [21:0] cnt_r, cnt_nxt, len_r;
	logic        busy_r, por_seen_r;
	logic [21:0] ph1, ph2;
	// Phase edges sit one and two PHASE_CLKS before the stretch end, whatever its length
	assign ph1 = len_r - 22'(2 * sgu_pkg::PHASE_CLKS);
	assign ph2 = len_r - 22'(sgu_pkg::PHASE_CLKS);
	assign cnt_nxt = any_src ? '0 : (busy_r ? cnt_r + 22'd1 : cnt_r);

	always_ff @(posedge clk_sys) begin
		if (src.por) begin
			len_r <= POR_HOLD;
		end else if (any_src & ~(por_seen_r & busy_r)) begin
			// Stale power-on flag must not lengthen a later ordinary reset
			len_r <= sgu_pkg::EXT_CLKS;
		end
	end

	always_ff @(posedge clk_sys) begin
		cnt_r <= cnt_nxt;
		if (any_src) begin
			busy_r <= 1'b1;
		end else if (busy_r && cnt_r == len_r - 22'd1) begin
			busy_r <= 1'b0;
		end
		if (src.por) begin
			por_seen_r <= 1'b1;
		end else if (!busy_r) begin
			por_seen_r <= 1'b0;
		end
	end

	// Three phased releases; all resets held while any source is active
	wire core_hold   = any_src | (busy_r & (cnt_r < ph1));
	wire mem_hold    = any_src | (busy_r & (cnt_r < ph2));
	wire periph_hold = any_src | busy_r;

	// Mode register: boot bits follow flash security after hard resets only
	logic [15:0] omr_r;
	always_ff @(posedge clk_sys) begin
		if (any_src) begin
			omr_r[15:2] <= sgu_pkg::OMR_RST[15:2];
			if (hard_src) begin
				omr_r[sgu_pkg::OMR_MA] <= flash_secure;
				omr_r[sgu_pkg::OMR_MB] <= flash_secure;
			end
		end else if (omr_we && !core_hold) begin
			// Core instructions only; no memory-mapped path exists
			omr_r <= omr_wdata & sgu_pkg::OMR_WMASK;
		end
	end // Watchdog/software reset leaves the boot bits as they were

	logic [15:0] scr_r [sgu_pkg::NSCR];
	always_ff @(posedge clk_sys) begin
		for (int i = 0; i < sgu_pkg::NSCR; i++) begin
			if (src.por) begin
				scr_r[i] <= sgu_pkg::SCR_RST;
			end else if (scr_we && !periph_hold && scr_sel == 2'(i)) begin
				scr_r[i] <= scr_wdata;
			end
		end
	end

	// Power mode machine
	sgu_pkg::sgu_pmode_e st_r, st_nxt;
	wire wake = can_activity | ungated_irq;
	always_comb begin
		st_nxt = st_r;
		case (st_r)
			sgu_pkg::SGU_RUN: begin
				if (stop_instr && !ctrl.stop_dis) begin
					st_nxt = sgu_pkg::SGU_STOP;
				end else if (wait_instr && !ctrl.wait_dis) begin
					st_nxt = sgu_pkg::SGU_WAIT;
				end
			end
			sgu_pkg::SGU_WAIT: if (ungated_irq) st_nxt = sgu_pkg::SGU_RUN;
			sgu_pkg::SGU_STOP: if (wake) st_nxt = sgu_pkg::SGU_RUN;
			default: st_nxt = sgu_pkg::SGU_RUN;
		endcase
	end

	wire in_wait = st_r == sgu_pkg::SGU_WAIT;
	wire in_stop = st_r == sgu_pkg::SGU_STOP;
	// PLL and oscillator are not touched here; software shuts them down
	wire core_on = ~(in_wait | in_stop);
	wire [15:0] per_on = in_stop ? 16'h0000 : pce;
	wire wdog_on = ~debug_mode
		& ~(in_wait & ctrl.wait_wdog_stop) & ~(in_stop & ctrl.stop_wdog_stop);
	// CAN stays clocked in stop unless gated, so it can wake the chip
	wire can_on = ~(in_stop & ctrl.stop_can_stop);
	wire pwm_off = (debug_mode & ctrl.dbg_pwm_off) | (in_wait & ctrl.wait_pwm_off);

	always_ff @(posedge clk_sys) begin
		if (any_src) begin
			st_r <= sgu_pkg::SGU_RUN;
		end else begin
			st_r <= st_nxt;
		end
		core_rst      <= core_hold;
		mem_rst       <= mem_hold;
		periph_rst    <= periph_hold;
		core_clk_en   <= core_on;
		mem_clk_en    <= core_on;
		periph_clk_en <= per_on;
		wdog_clk_en   <= wdog_on;
		can_clk_en    <= can_on;
		pwm_force_off <= pwm_off;
		pmode         <= st_r;
		omr_q         <= omr_r;
		scr_q         <= {scr_r[3], scr_r[2], scr_r[1], scr_r[0]};
	end

	// Assertions
	property p_ext_hold;
		@(posedge clk_sys) disable iff (srst)
		$fell(any_src) && !por_seen_r |-> periph_hold [*8];
	endproperty
	a_ext_hold: assert property (p_ext_hold) else $error("Stretch too short");

	// A new source aborts the attempt, since the count starts over
	property p_ext_len;
		@(posedge clk_sys) disable iff (srst || any_src)
		$fell(any_src) && !por_seen_r |-> ##[96:97] !periph_hold;
	endproperty
	a_ext_len: assert property (p_ext_len) else $error("Stretch length wrong");

	property p_hard_rst;
		@(posedge clk_sys) hard_src |=> core_rst && mem_rst && periph_rst;
	endproperty
	a_hard_rst: assert property (p_hard_rst) else $error("Hard reset not applied");

	property p_boot_keep;
		@(posedge clk_sys) disable iff (srst)
		(wdog_rst || sw_rst) && !hard_src |=>
			omr_r[1:0] == $past(omr_r[1:0]) && omr_r[15:2] == sgu_pkg::OMR_RST[15:2];
	endproperty
	a_boot_keep: assert property (p_boot_keep) else $error("Boot bit lost");

	property p_dbg_wdog;
		@(posedge clk_sys) debug_mode |=> !wdog_clk_en;
	endproperty
	a_dbg_wdog: assert property (p_dbg_wdog) else $error("Watchdog clocked in debug");

	property p_wait_gate;
		@(posedge clk_sys) in_wait |=> !core_clk_en && !mem_clk_en;
	endproperty
	a_wait_gate: assert property (p_wait_gate) else $error("Core clock in wait");

	property p_stop_gate;
		@(posedge clk_sys) in_stop |=> !core_clk_en && periph_clk_en == 16'h0000;
	endproperty
	a_stop_gate: assert property (p_stop_gate) else $error("Clock running in stop");

	property p_wake;
		@(posedge clk_sys) disable iff (srst)
		in_stop && wake && !any_src |=> st_r == sgu_pkg::SGU_RUN;
	endproperty
	a_wake: assert property (p_wake) else $error("No wake");

	// Writes and power-on clears reach the output two edges later
	property p_scr_keep;
		@(posedge clk_sys) disable iff (srst)
		!src.por && !scr_we |=>
			scr_q == $past(scr_q) || $past(scr_we, 2) || $past(src.por, 2);
	endproperty
	a_scr_keep: assert property (p_scr_keep) else $error("Software register lost");

	property p_stop_dis;
		@(posedge clk_sys) disable iff (srst)
		st_r == sgu_pkg::SGU_RUN && ctrl.stop_dis && ctrl.wait_dis |=> !in_stop && !in_wait;
	endproperty
	a_stop_dis: assert property (p_stop_dis) else $error("Disabled instruction entered");

	property p_restart;
		@(posedge clk_sys) any_src |=> cnt_r == 22'd0;
	endproperty
	a_restart: assert property (p_restart) else $error("Count not restarted");

	c_wait: cover property (@(posedge clk_sys) in_wait ##1 !in_wait);
	c_stop: cover property (@(posedge clk_sys) in_stop ##1 can_activity);
	c_swrst: cover property (@(posedge clk_sys) sw_rst ##1 !sw_rst);
endmodule : sgu_top

/* shared/sgu_pkg.sv */
// Purpose: constants and types for the system glue unit
// Assumes: single 10 MHz clock, synchronous active-high reset
// Notes:   mode register is reached only by core instructions
//
// Overview of operation
// - An ordinary reset is stretched by three phased releases of 32 clocks, a power-on one by 2**21 clocks.
// - Power-on detect or the low reset pin resets the core and every peripheral.
// - Watchdog or software reset resets everything but the software registers and keeps the two boot bits of the mode register.
// - Debug mode keeps peripherals running but stops the watchdog and may force PWM off.
// - Wait mode gates core and memory clocks, with optional watchdog stop and PWM off.
// - Stop mode gates core, memory and all peripheral clocks, optionally watchdog and CAN too.
// - Stop mode ends on CAN activity or any interrupt whose clock is not gated.
// - Four 16-bit software registers are cleared only by power-on reset.
// - Software bits separately disable the wait and stop instructions.
// - Each peripheral clock can be gated on its own.
// - The mode register clears on reset except its two boot bits, set from flash security.
// - The mode register sits with the core and is written only by core instructions.
package sgu_pkg;
	localparam int          PHASE_CLKS  = 32;
	localparam int          PHASES      = 3;
	localparam int          POR_EXP     = 21;
	localparam int          CNT_W       = 22;
	localparam int          NPERIPH     = 16;
	localparam int          NSCR        = 4;
	localparam logic [15:0] OMR_RST     = 16'h0000;
	localparam logic [15:0] OMR_WMASK   = 16'h81fb;
	localparam int          OMR_MA      = 0;
	localparam int          OMR_MB      = 1;
	localparam logic [15:0] SCR_RST     = 16'h0000;
	localparam logic [15:0] PCE_RST     = 16'hffff;

	typedef enum logic [1:0] {
		SGU_RUN  = 2'b00,
		SGU_WAIT = 2'b01,
		SGU_STOP = 2'b11
	} sgu_pmode_e;

	typedef struct packed {
		logic por;
		logic ext;
		logic wdog;
		logic sw;
	} sgu_rsrc_s;

	typedef struct packed {
		logic wait_dis;
		logic stop_dis;
		logic wait_wdog_stop;
		logic wait_pwm_off;
		logic stop_wdog_stop;
		logic stop_can_stop;
		logic dbg_pwm_off;
	} sgu_ctrl_s;

	localparam logic [CNT_W-1:0] POR_CLKS = CNT_W'(1) << POR_EXP;
	localparam logic [CNT_W-1:0] EXT_CLKS = CNT_W'(PHASES * PHASE_CLKS);
endpackage : sgu_pkg

/* tb/sgu_core_model.sv */
// Purpose: core-side partner issuing wait and stop instructions
// Assumes: requests from the bench arrive on clk_sys
// Notes:   PLL and oscillator shutdown is left to software
`timescale 1ns/100ps
module sgu_core_model (
	input  wire logic clk_sys,
	input  wire logic do_wait,
	input  wire logic do_stop,
	output logic      wait_instr,
	output logic      stop_instr
);
	// One-cycle pulses, as the core executes them; PLL untouched
	always_ff @(posedge clk_sys) begin
		wait_instr <= do_wait;
		stop_instr <= do_stop;
	end
endmodule : sgu_core_model

/* tb/testbench.sv */
// Purpose: self-checking bench for the system glue unit
// Assumes: power-on hold shortened to 200 clocks
// Notes:   expected state kept in plain variables
`timescale 1ns/100ps
module testbench;
	localparam int POR = 200;
	logic clk_sys, srst, por_det, rst_pin_n, wdog_rst, sw_rst, flash_secure, debug_mode;
	logic wait_instr, stop_instr, can_activity, ungated_irq, omr_we, scr_we, do_wait, do_stop;
	logic core_rst, mem_rst, periph_rst, core_clk_en, mem_clk_en, wdog_clk_en, pwm_force_off;
	logic [1:0]  scr_sel, pmode;
	logic [15:0] pce, omr_wdata, scr_wdata, periph_clk_en, omr_q, m_omr;
	logic [15:0] m_scr [$];
	logic [63:0] scr_q;
	logic        can_clk_en;
	sgu_pkg::sgu_ctrl_s ctrl, c;
	sgu_pkg::sgu_pmode_e st;
	int errors, n_compared, seed, i;

	sgu_top #(.POR_HOLD(22'(POR))) i_sgu_top (.clk_sys(clk_sys), .srst(srst),
		.por_det(por_det), .rst_pin_n(rst_pin_n), .wdog_rst(wdog_rst), .sw_rst(sw_rst),
		.flash_secure(flash_secure), .debug_mode(debug_mode), .wait_instr(wait_instr),
		.stop_instr(stop_instr), .can_activity(can_activity), .ungated_irq(ungated_irq),
		.ctrl(ctrl), .pce(pce), .omr_we(omr_we), .omr_wdata(omr_wdata), .scr_we(scr_we),
		.scr_sel(scr_sel), .scr_wdata(scr_wdata), .core_rst(core_rst), .mem_rst(mem_rst),
		.periph_rst(periph_rst), .core_clk_en(core_clk_en), .mem_clk_en(mem_clk_en),
		.periph_clk_en(periph_clk_en), .wdog_clk_en(wdog_clk_en), .can_clk_en(can_clk_en),
		.pwm_force_off(pwm_force_off), .pmode(pmode), .omr_q(omr_q), .scr_q(scr_q));
	sgu_core_model i_sgu_core_model (.clk_sys(clk_sys), .do_wait(do_wait),
		.do_stop(do_stop), .wait_instr(wait_instr), .stop_instr(stop_instr));

	task automatic chk(input logic [63:0] g, input logic [63:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			errors++;
			$display("Error at %0t: %s", $time, m);
		end
	endtask : chk

	task automatic give_verdict;
		$display("compared %0d, errors %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : give_verdict

	// Sync flops make the exact edge fuzzy, so allow a small window
	task automatic rel(input int len);
		int   n, nc, nm;
		logic seen;
		n = 0;
		nc = 0;
		nm = 0;
		seen = 1'b0;
		// Pin and detector requests need two sync cycles before reset shows
		while ((!seen || periph_rst !== 1'b0) && n < len + 9) begin
			@(negedge clk_sys);
			n++;
			seen |= periph_rst === 1'b1;
			if (core_rst !== 1'b0) nc = n;
			if (mem_rst !== 1'b0) nm = n;
		end
		chk(n > len - 5 && n < len + 8, 1, "reset length");
		// Last held cycle to first free one, hence one extra clock
		chk(n - nc == 2 * sgu_pkg::PHASE_CLKS + 1, 1, "core release");
		chk(n - nm == sgu_pkg::PHASE_CLKS + 1, 1, "memory release");
		chk({core_rst, mem_rst}, 0, "phase release");
	endtask : rel

	task automatic hit(input int k);
		@(posedge clk_sys);
		sw_rst <= k == 0;
		wdog_rst <= k == 1;
		rst_pin_n <= k != 2;
		@(posedge clk_sys);
		sw_rst <= 1'b0;
		wdog_rst <= 1'b0;
		rst_pin_n <= 1'b1;
	endtask : hit

	task automatic wr(input logic om, input logic [1:0] s, input logic [15:0] d);
		@(posedge clk_sys);
		omr_we <= om;
		scr_we <= !om;
		scr_sel <= s;
		omr_wdata <= d;
		scr_wdata <= d;
		@(posedge clk_sys);
		omr_we <= 1'b0;
		scr_we <= 1'b0;
		if (om) m_omr = d & sgu_pkg::OMR_WMASK;
		else m_scr[s] = d;
	endtask : wr

	task automatic regs;
		// Register outputs trail a write by two edges
		repeat (2) @(negedge clk_sys);
		chk(scr_q, {m_scr[3], m_scr[2], m_scr[1], m_scr[0]}, "scr");
		chk(omr_q, m_omr, "omr");
	endtask : regs

	initial begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		errors++;
		give_verdict();
	end

	initial begin
		seed = 32'h78b9;
		{srst, rst_pin_n, flash_secure, pce} = {3'b111, 16'hffff};
		{por_det, wdog_rst, sw_rst, debug_mode, do_wait, do_stop} = 0;
		{can_activity, ungated_irq, omr_we, scr_we, scr_sel, omr_wdata, scr_wdata} = 0;
		ctrl = '0;
		m_omr = 16'h0003;
		m_scr = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
		repeat (20) @(posedge clk_sys);
		srst <= 1'b0;
		rel(POR);
		regs();
		for (i = 0; i < 5; i++) wr(i == 4, i[1:0], 16'($random(seed)));
		regs();
		for (i = 0; i < 2; i++) begin
			hit(i);
			rel(96);
			m_omr &= 16'h0003;
			regs();
		end
		// Second source mid-stretch must restart the count
		hit(0);
		repeat (50) @(posedge clk_sys);
		hit(1);
		rel(96);
		flash_secure <= 1'b0;
		hit(2);
		rel(98);
		m_omr = 16'h0000;
		regs();
		for (i = 0; i < 4; i++) begin
			c = sgu_pkg::sgu_ctrl_s'(7'($random(seed)));
			if (i < 2) {c.wait_dis, c.stop_dis} = 2'b00;
			else {c.wait_dis, c.stop_dis} = 2'b11;
			@(posedge clk_sys);
			ctrl <= c;
			pce <= 16'($random(seed));
			do_wait <= !i[0];
			do_stop <= i[0];
			@(posedge clk_sys);
			{do_wait, do_stop} <= 2'b00;
			repeat (3) @(negedge clk_sys);
			st = i[0] ? (c.stop_dis ? sgu_pkg::SGU_RUN : sgu_pkg::SGU_STOP)
				: (c.wait_dis ? sgu_pkg::SGU_RUN : sgu_pkg::SGU_WAIT);
			chk(pmode, st, "mode");
			chk({core_clk_en, mem_clk_en}, {2{st == sgu_pkg::SGU_RUN}}, "core gate");
			chk(periph_clk_en, st == sgu_pkg::SGU_STOP ? 16'h0 : pce, "periph gate");
			chk(wdog_clk_en, !(st == sgu_pkg::SGU_WAIT && c.wait_wdog_stop
				|| st == sgu_pkg::SGU_STOP && c.stop_wdog_stop), "wdog gate");
			chk({can_clk_en, pwm_force_off}, {!(st == sgu_pkg::SGU_STOP && c.stop_can_stop),
				st == sgu_pkg::SGU_WAIT && c.wait_pwm_off}, "can pwm gate");
			@(posedge clk_sys);
			can_activity <= i == 1;
			ungated_irq <= i != 1;
			@(posedge clk_sys);
			{can_activity, ungated_irq} <= 2'b00;
			repeat (3) @(negedge clk_sys);
			chk(pmode, sgu_pkg::SGU_RUN, "wake");
		end
		// Power-on detector mid-run clears the software registers
		@(posedge clk_sys);
		por_det <= 1'b1;
		@(posedge clk_sys);
		por_det <= 1'b0;
		rel(POR + 2);
		m_scr = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
		m_omr = 16'h0000;
		regs();
		@(posedge clk_sys);
		debug_mode <= 1'b1;
		repeat (3) @(negedge clk_sys);
		chk({wdog_clk_en, pwm_force_off}, {1'b0, c.dbg_pwm_off}, "debug");
		give_verdict();
	end
endmodule : testbench
